// [logic/peripheral_clock_gating.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Peripheral clock gating with run, sleep and deep-sleep gate sets.
module peripheral_clock_gating (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_srst,
  // Register port.
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Power mode requests.
  input wire logic i_sleep,
  input wire logic i_deep_sleep,
  // Peripheral bus accesses, one bit per unit.
  input wire logic [2:0] i_unit_access,
  output logic o_bus_fault,
  output logic [2:0] o_fault_unit,
  // Unit clock enables and gated clocks.
  output logic o_can_unit_zero_clk_en,
  output logic o_conv_clk_en,
  output logic o_watchdog_clk_en,
  output logic o_can_gclk,
  output logic o_conv_gclk,
  output logic o_wdog_gclk,
  // Converter rate selection.
  output logic [1:0] o_converter_rate_sel,
  // Interrupt.
  output logic o_irq
);

  // ========================================================================
  // Storage.
  logic [31:0] run_gate_reg_q;
  logic [31:0] run_gate_reg_d;
  logic [31:0] sleep_gate_reg_q;
  logic [31:0] sleep_gate_reg_d;
  logic [31:0] deep_sleep_gate_reg_q;
  logic [31:0] deep_sleep_gate_reg_d;
  logic [31:0] run_clock_config_reg_q;
  logic [31:0] run_clock_config_reg_d;
  logic [2:0] irq_status_q;
  logic [2:0] irq_status_d;
  logic [2:0] irq_enable_q;
  logic [2:0] irq_enable_d;
  pcg_pkg::power_mode_t mode_q;
  pcg_pkg::power_mode_t mode_d;
  logic [2:0] unit_en_q;
  logic [2:0] unit_en_d;
  logic [1:0] rate_q;
  logic [1:0] rate_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic fault_q;
  logic [2:0] fault_unit_q;
  logic [2:0] fault_unit_d;
  logic irq_q;
  logic irq_d;
  logic [2:0] gclk;

  // ========================================================================
  // Address decode.
  wire wr_run = i_wr && (i_addr == pcg_pkg::RUN_GATE_OFS);
  wire wr_sleep = i_wr && (i_addr == pcg_pkg::SLEEP_GATE_OFS);
  wire wr_deep = i_wr && (i_addr == pcg_pkg::DEEP_GATE_OFS);
  wire wr_cfg = i_wr && (i_addr == pcg_pkg::RUN_CFG_OFS);
  wire wr_clear = i_wr && (i_addr == pcg_pkg::IRQ_CLEAR_OFS);
  wire wr_enable = i_wr && (i_addr == pcg_pkg::IRQ_ENABLE_OFS);

  // Only writable gate bits are stored; reserved bits keep fixed values.
  wire [31:0] gate_wdata = i_wdata & pcg_pkg::GATE_WR_MASK;
  assign run_gate_reg_d = wr_run ? gate_wdata : run_gate_reg_q;
  assign sleep_gate_reg_d = wr_sleep ? gate_wdata : sleep_gate_reg_q;
  assign deep_sleep_gate_reg_d = wr_deep ? gate_wdata : deep_sleep_gate_reg_q;
  assign run_clock_config_reg_d = wr_cfg ?
      {31'h0000_0000, i_wdata[pcg_pkg::AUTO_GATING_BIT]} :
      run_clock_config_reg_q;

  // ========================================================================
  // Power mode and gate set selection.
  wire auto_gating_sel = run_clock_config_reg_q[pcg_pkg::AUTO_GATING_BIT];

  // The current mode is taken from the requests, deep sleep first.
  always_comb begin
    if (i_deep_sleep) begin
      mode_d = pcg_pkg::MODE_DEEP;
    end else if (i_sleep) begin
      mode_d = pcg_pkg::MODE_SLEEP;
    end else begin
      mode_d = pcg_pkg::MODE_RUN;
    end
  end

  // The gate set follows the mode, and the run set is used unless
  // automatic gating is set.
  always_comb begin
    unit_en_d = pcg_pkg::unit_bits(run_gate_reg_q);
    rate_d = run_gate_reg_q[pcg_pkg::RATE_MSB:pcg_pkg::RATE_LSB];
    unique case (mode_q)
      pcg_pkg::MODE_RUN: begin
        unit_en_d = pcg_pkg::unit_bits(run_gate_reg_q);
      end
      pcg_pkg::MODE_SLEEP: begin
        if (auto_gating_sel) begin
          unit_en_d = pcg_pkg::unit_bits(sleep_gate_reg_q);
          rate_d = sleep_gate_reg_q[pcg_pkg::RATE_MSB:pcg_pkg::RATE_LSB];
        end
      end
      pcg_pkg::MODE_DEEP: begin
        if (auto_gating_sel) begin
          unit_en_d = pcg_pkg::unit_bits(deep_sleep_gate_reg_q);
          rate_d = deep_sleep_gate_reg_q[pcg_pkg::RATE_MSB:pcg_pkg::RATE_LSB];
        end
      end
      default: begin
        unit_en_d = pcg_pkg::UNIT_RESET;
      end
    endcase
  end

  // ========================================================================
  // Fault detection and interrupt.
  wire [2:0] fault_hit = i_unit_access & ~unit_en_q;
  assign fault_unit_d = fault_hit;

  // A new fault wins over a clear in the same cycle.
  assign irq_status_d = (irq_status_q & ~(wr_clear ? i_wdata[2:0] : 3'h0))
      | fault_hit;
  assign irq_enable_d = wr_enable ? i_wdata[2:0] : irq_enable_q;
  assign irq_d = |(irq_status_d & irq_enable_d);

  // ========================================================================
  // Read mux; unmapped and write-only addresses read as zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (i_rd) begin
      unique case (i_addr)
        pcg_pkg::RUN_GATE_OFS: begin
          rdata_d = pcg_pkg::gate_view(run_gate_reg_q);
        end
        pcg_pkg::SLEEP_GATE_OFS: begin
          rdata_d = pcg_pkg::gate_view(sleep_gate_reg_q);
        end
        pcg_pkg::DEEP_GATE_OFS: begin
          rdata_d = pcg_pkg::gate_view(deep_sleep_gate_reg_q);
        end
        pcg_pkg::RUN_CFG_OFS: begin
          rdata_d = run_clock_config_reg_q;
        end
        pcg_pkg::IRQ_STATUS_OFS: begin
          rdata_d = {29'h0000_0000, irq_status_q};
        end
        pcg_pkg::IRQ_ENABLE_OFS: begin
          rdata_d = {29'h0000_0000, irq_enable_q};
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // ========================================================================
  // Register file and control flops.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      run_gate_reg_q <= pcg_pkg::GATE_RESET;
      sleep_gate_reg_q <= pcg_pkg::GATE_RESET;
      deep_sleep_gate_reg_q <= pcg_pkg::GATE_RESET;
      run_clock_config_reg_q <= pcg_pkg::CFG_RESET;
    end else begin
      run_gate_reg_q <= run_gate_reg_d;
      sleep_gate_reg_q <= sleep_gate_reg_d;
      deep_sleep_gate_reg_q <= deep_sleep_gate_reg_d;
      run_clock_config_reg_q <= run_clock_config_reg_d;
    end
  end

  // Gating state and fault report flops.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mode_q <= pcg_pkg::MODE_RUN;
      unit_en_q <= pcg_pkg::UNIT_RESET;
      rate_q <= pcg_pkg::RATE_125K;
      fault_q <= 1'b0;
      fault_unit_q <= 3'h0;
    end else begin
      mode_q <= mode_d;
      unit_en_q <= unit_en_d;
      rate_q <= rate_d;
      fault_q <= |fault_hit;
      fault_unit_q <= fault_unit_d;
    end
  end

  // Interrupt and read data flops.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_status_q <= 3'h0;
      irq_enable_q <= 3'h0;
      irq_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      irq_status_q <= irq_status_d;
      irq_enable_q <= irq_enable_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  // ========================================================================
  // Glitch free clock gates, one per unit.
  for (genvar g = 0; g < pcg_pkg::UNIT_COUNT; g++) begin : g_gate
    clock_gate_cell u_gate (
      .i_clk(i_clk),
      .i_en(unit_en_q[g]),
      .o_gclk(gclk[g])
    );
  end

  // ========================================================================
  // Outputs.
  assign o_rdata = rdata_q;
  assign o_bus_fault = fault_q;
  assign o_fault_unit = fault_unit_q;
  assign o_can_unit_zero_clk_en = unit_en_q[pcg_pkg::UNIT_CAN];
  assign o_conv_clk_en = unit_en_q[pcg_pkg::UNIT_CONV];
  assign o_watchdog_clk_en = unit_en_q[pcg_pkg::UNIT_WDOG];
  assign o_can_gclk = gclk[pcg_pkg::UNIT_CAN];
  assign o_conv_gclk = gclk[pcg_pkg::UNIT_CONV];
  assign o_wdog_gclk = gclk[pcg_pkg::UNIT_WDOG];
  assign o_converter_rate_sel = rate_q;
  assign o_irq = irq_q;

  // ========================================================================
  // Checks.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  AST_EN_FOLLOWS_SET: assert property (
    mode_q == pcg_pkg::MODE_RUN
      |=> unit_en_q == pcg_pkg::unit_bits($past(run_gate_reg_q)))
    else $error("Unit enables do not follow the run gate set.");

  AST_FAULT_ON_GATED: assert property (
    (|(i_unit_access & ~unit_en_q)) |=> o_bus_fault
      && o_fault_unit == $past(i_unit_access & ~unit_en_q))
    else $error("Access to an unclocked unit did not fault.");

  AST_NO_FAULT_ON_CLOCKED: assert property (
    !(|(i_unit_access & ~unit_en_q)) |=> !o_bus_fault)
    else $error("Bus fault without an access to an unclocked unit.");

  AST_RESET_VALUES: assert property (
    $past(i_srst) |-> run_gate_reg_q == pcg_pkg::GATE_RESET
      && sleep_gate_reg_q == pcg_pkg::GATE_RESET && unit_en_q == 3'h0)
    else $error("Gate state is not at its reset value.");

  AST_DEEP_SET: assert property (
    (mode_q == pcg_pkg::MODE_DEEP && auto_gating_sel)
      |=> unit_en_q == pcg_pkg::unit_bits($past(deep_sleep_gate_reg_q)))
    else $error("Deep sleep set not applied.");

  AST_SLEEP_SET: assert property (
    (mode_q == pcg_pkg::MODE_SLEEP && auto_gating_sel)
      |=> unit_en_q == pcg_pkg::unit_bits($past(sleep_gate_reg_q)))
    else $error("Sleep set not applied.");

  AST_RUN_WITHOUT_AUTO: assert property (
    !auto_gating_sel |=> unit_en_q == pcg_pkg::unit_bits($past(run_gate_reg_q)))
    else $error("Sleep sets applied without auto gating.");

  AST_SLEEP_READBACK: assert property (
    (i_rd && i_addr == pcg_pkg::SLEEP_GATE_OFS)
      |=> o_rdata == pcg_pkg::gate_view($past(sleep_gate_reg_q)))
    else $error("Sleep gate register read back wrong.");

  AST_SLEEP_WRITE: assert property (
    (i_wr && i_addr == pcg_pkg::SLEEP_GATE_OFS)
      |=> sleep_gate_reg_q[pcg_pkg::CAN_BIT] == $past(i_wdata[24])
      && sleep_gate_reg_q[pcg_pkg::CONV_BIT] == $past(i_wdata[16])
      && sleep_gate_reg_q[pcg_pkg::WDOG_BIT] == $past(i_wdata[3]))
    else $error("Sleep gate enable bit not stored.");

  AST_RATE_FIELD: assert property (
    (i_wr && i_addr == pcg_pkg::SLEEP_GATE_OFS) |=> sleep_gate_reg_q[9:8]
      == $past(i_wdata[9:8]))
    else $error("Rate field not stored.");

  AST_RESERVED_READ: assert property (
    (i_rd && (i_addr == pcg_pkg::RUN_GATE_OFS
      || i_addr == pcg_pkg::SLEEP_GATE_OFS
      || i_addr == pcg_pkg::DEEP_GATE_OFS))
      |=> (o_rdata & ~pcg_pkg::GATE_WR_MASK) == 32'h0000_0040)
    else $error("Reserved gate bits read wrong.");

endmodule : peripheral_clock_gating

`default_nettype wire

// [logic/pcg_pkg.sv]

// ==========================================================================
// Shared constants of the peripheral clock gating block.
package pcg_pkg;

  // Register byte offsets.
  localparam logic [11:0] RUN_GATE_OFS = 12'h100;
  localparam logic [11:0] SLEEP_GATE_OFS = 12'h110;
  localparam logic [11:0] DEEP_GATE_OFS = 12'h120;
  localparam logic [11:0] RUN_CFG_OFS = 12'h130;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h140;
  localparam logic [11:0] IRQ_CLEAR_OFS = 12'h144;
  localparam logic [11:0] IRQ_ENABLE_OFS = 12'h148;

  // Field positions in the gate registers and the run clock config register.
  localparam int CAN_BIT = 24;
  localparam int CONV_BIT = 16;
  localparam int RATE_LSB = 8;
  localparam int RATE_MSB = 9;
  localparam int WDOG_BIT = 3;
  localparam int AUTO_GATING_BIT = 0;

  // Unit indices in the three-bit unit vectors.
  localparam int UNIT_WDOG = 0;
  localparam int UNIT_CONV = 1;
  localparam int UNIT_CAN = 2;
  localparam int UNIT_COUNT = 3;

  // Writable bits, fixed read-only bits and values after reset.
  localparam logic [31:0] GATE_WR_MASK = 32'h0101_0308;
  localparam logic [31:0] GATE_FIXED_ONES = 32'h0000_0040;
  localparam logic [31:0] GATE_RESET = 32'h0000_0040;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [2:0] UNIT_RESET = 3'h0;

  // Converter rate codes.
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [1:0] RATE_500K = 2'h2;
  localparam logic [1:0] RATE_250K = 2'h1;
  localparam logic [1:0] RATE_125K = 2'h0;

  // Power modes as seen by the gating logic.
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} power_mode_t;

  // Picks the three unit enables out of a gate register.
  function automatic logic [2:0] unit_bits(input logic [31:0] r);
    unit_bits = {r[CAN_BIT], r[CONV_BIT], r[WDOG_BIT]};
  endfunction : unit_bits

  // Builds the read view of a gate register from its stored bits.
  function automatic logic [31:0] gate_view(input logic [31:0] r);
    gate_view = (r & GATE_WR_MASK) | GATE_FIXED_ONES;
  endfunction : gate_view

endpackage : pcg_pkg

// [logic/clock_gate_cell.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Latch based clock gate that never truncates a clock pulse.
module clock_gate_cell (
  // Source clock.
  input wire logic i_clk,
  // Registered enable.
  input wire logic i_en,
  // Gated clock.
  output logic o_gclk
);

  logic en_l;

  // The enable is passed only while the clock is low, so it is stable
  // through the whole high phase and no glitch can reach the output.
  always_latch begin
    if (!i_clk) begin
      en_l = i_en;
    end
  end

  // The gated clock follows the source while the latched enable is high.
  assign o_gclk = i_clk & en_l;

endmodule : clock_gate_cell

`default_nettype wire

// [logic/_end_marker_unused.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Self-checking bench of the peripheral clock gating block.
module testbench;
  // Design ports.
  logic i_clk, i_srst, i_wr, i_rd, i_sleep, i_deep_sleep;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [2:0] i_unit_access, o_fault_unit;
  logic o_bus_fault, o_can_unit_zero_clk_en, o_conv_clk_en;
  logic o_watchdog_clk_en, o_can_gclk, o_conv_gclk, o_wdog_gclk, o_irq;
  logic [1:0] o_converter_rate_sel;
  // Bench state.
  logic [31:0] exp_q[$];
  logic [11:0] ofs [3] = '{12'h100, 12'h110, 12'h120};
  logic [31:0] w, r, s, d, e;
  logic [2:0] m;
  logic rd_seen;
  int fails, cmp_count, i;
  integer seed;

  peripheral_clock_gating dut (
    .i_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_sleep, .i_deep_sleep, .i_unit_access, .o_bus_fault, .o_fault_unit,
    .o_can_unit_zero_clk_en, .o_conv_clk_en, .o_watchdog_clk_en,
    .o_can_gclk, .o_conv_gclk, .o_wdog_gclk, .o_converter_rate_sel, .o_irq
  );

  // Free running system clock.
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // One register write cycle.
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // One register read cycle; the expected word is noted for the monitor.
  task automatic rd(input logic [11:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(v);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : rd

  // One access pulse to the peripheral units.
  task automatic acc(input logic [2:0] u);
    @(posedge i_clk);
    i_unit_access <= u;
    @(posedge i_clk);
    i_unit_access <= 3'h0;
    @(negedge i_clk);
  endtask : acc

  // Lets a fixed number of cycles pass, then stops in the low phase.
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : wait_n

  // Checks enables, rate and both phases of the gated clocks against v.
  task automatic units(input logic [31:0] v);
    logic [2:0] en;
    en = {v[pcg_pkg::CAN_BIT], v[pcg_pkg::CONV_BIT], v[pcg_pkg::WDOG_BIT]};
    chk({o_can_unit_zero_clk_en, o_conv_clk_en, o_watchdog_clk_en}, en);
    chk(o_converter_rate_sel, v[9:8]);
    #1;
    chk({o_can_gclk, o_conv_gclk, o_wdog_gclk}, 3'h0);
    @(posedge i_clk);
    #1;
    chk({o_can_gclk, o_conv_gclk, o_wdog_gclk}, en);
  endtask : units

  // Resets the block and checks every register and every output but o_fault_unit afterwards.
  task automatic rst_chk();
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      rd(ofs[k], 32'h0000_0040);
    end
    rd(12'h130, 32'h0);
    rd(12'h140, 32'h0);
    rd(12'h148, 32'h0);
    rd(12'h1FC, 32'h0);
    wait_n(1);
    units(32'h0000_0040);
    chk({o_bus_fault, o_irq}, 2'h0);
  endtask : rst_chk

  // Read data stand in the cycle after the strobe; compare with the note.
  always @(posedge i_clk) rd_seen <= i_rd;
  always @(negedge i_clk) begin
    if (rd_seen === 1'b1) begin
      chk(o_rdata, exp_q.pop_front());
    end
  end

  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    conclude();
  end

  // Main sequence.
  initial begin
    {i_srst, i_wr, i_rd, i_sleep, i_deep_sleep} = 5'h10;
    {i_addr, i_wdata, i_unit_access} = '0;
    seed = 32'h0451670d;
    rst_chk();
    // Random words read back with reserved bits fixed.
    for (i = 0; i < 6; i++) begin
      w = $random(seed);
      wr(ofs[i % 3], w);
      rd(ofs[i % 3], (w & 32'h0101_0308) | 32'h0000_0040);
    end
    wr(12'h140, 32'hFFFF_FFFF);
    rd(12'h140, 32'h0);
    // Every rate code with random enables in run mode; the bench takes
    // every code as one that this build supports.
    for (i = 0; i < 4; i++) begin
      w = ($random(seed) & 32'h0101_0008) | {22'h0, i[1:0], 8'h00};
      wr(12'h100, w);
      wait_n(2);
      units(w);
    end
    // Every mode and auto gating combination picks its gate set.
    // Reserved bit 6 is written back as it reads.
    r = 32'h0000_0148;
    s = 32'h0100_0240;
    d = 32'h0001_0348;
    wr(12'h100, r);
    wr(12'h110, s);
    wr(12'h120, d);
    for (i = 0; i < 8; i++) begin
      m = i[2:0];
      e = m[2] ? (m[1] ? d : (m[0] ? s : r)) : r;
      wr(12'h130, {31'h0, m[2]});
      i_sleep <= m[0];
      i_deep_sleep <= m[1];
      wait_n(3);
      units(e);
    end
    i_sleep <= 1'b0;
    i_deep_sleep <= 1'b0;
    // Accesses to unclocked units fault; only the enabled one interrupts.
    wr(12'h100, 32'h0);
    wr(12'h130, 32'h0);
    wr(12'h148, 32'h4);
    wait_n(2);
    for (i = 0; i < 3; i++) begin
      acc(3'h1 << i);
      chk({o_bus_fault, o_fault_unit}, {1'b1, 3'h1 << i});
      chk(o_irq, i == 2);
    end
    rd(12'h140, 32'h7);
    wr(12'h144, 32'h7);
    wait_n(1);
    chk(o_irq, 1'b0);
    rd(12'h140, 32'h0);
    // Clocked units take accesses without a fault.
    wr(12'h100, 32'h0101_0008);
    wait_n(2);
    acc(3'h7);
    chk({o_bus_fault, o_fault_unit, o_irq}, 5'h0);
    // Second reset in mid-run.
    wr(12'h110, 32'hFFFF_FFFF);
    rst_chk();
    for (i = 0; i < 10 && exp_q.size() > 0; i++) begin
      @(posedge i_clk);
    end
    if (exp_q.size() > 0) begin
      fails++;
    end
    conclude();
  end

endmodule : testbench

`default_nettype wire
